// >>> core/switch_spi_pkg.sv
// Constants, word layouts and register bundles of the switch serial command port.
// Assumes nothing of its surroundings; shared by the port, its checker and its bench.
package switch_spi_pkg;

	// Serial word geometry
	localparam int unsigned WORD_BITS     = 16;
	localparam int unsigned DATA_BITS     = 9;
	localparam int unsigned CNT_BITS      = 4;

	// Input register addresses (bits 12..10 of an input word)
	localparam logic [2:0] IN_READBACK    = 3'h0;
	localparam logic [2:0] IN_DUTY        = 3'h1;
	localparam logic [2:0] IN_CHAN_CONF   = 3'h2;
	localparam logic [2:0] IN_OVERCURRENT = 3'h4;
	localparam logic [2:0] IN_RETRY       = 3'h5;
	localparam logic [2:0] IN_GLOBAL      = 3'h6;
	localparam logic [2:0] IN_CALIBRATE   = 3'h7;

	// Output register codes (bank bit is the prefix)
	localparam logic [2:0] OUT_STATUS     = 3'h0;
	localparam logic [2:0] OUT_FAULT      = 3'h1;
	localparam logic [2:0] OUT_DUTY       = 3'h2;
	localparam logic [2:0] OUT_CHAN_CONF  = 3'h3;
	localparam logic [2:0] OUT_OVERCUR    = 3'h4;
	localparam logic [2:0] OUT_RETRY      = 3'h5;
	localparam logic [2:0] OUT_GLOBAL     = 3'h6;
	localparam logic [2:0] OUT_DIAG       = 3'h7;

	// Field positions and fixed patterns
	localparam int unsigned GCR_PARALLEL_POS = 6;
	localparam int unsigned GCR_VDDFAIL_POS  = 3;
	localparam logic [9:0]  CAL_PATTERN      = 10'h15B;
	localparam logic [8:0]  RETRY_WR_MASK    = 9'h10F;

	// Values after reset
	localparam logic [8:0]  REG_RESET        = 9'h000;
	localparam logic [3:0]  SEL_RESET        = 4'h0;
	localparam logic [15:0] TX_RESET         = 16'h0000;

	typedef struct packed {
		logic       wd;
		logic       parity;
		logic       bank;
		logic [2:0] addr;
		logic [9:0] data;
	} in_word_t;

	typedef struct packed {
		logic       wd;
		logic       parity_fault;
		logic [3:0] sel;
		logic       normal_mode;
		logic [8:0] data;
	} out_word_t;

	// Software-written settings presented to the switch core
	typedef struct packed {
		logic [1:0][8:0] duty;
		logic [1:0][8:0] chan_conf;
		logic [1:0][8:0] overcurrent;
		logic [1:0][8:0] retry;
		logic [8:0]      global_conf;
	} config_t;

	// Live state from the switch core
	typedef struct packed {
		logic [8:0]      status;
		logic [1:0][8:0] fault;
		logic [1:0][3:0] retry_count;
		logic [8:0]      diag;
		logic            normal_mode;
	} live_t;

endpackage

// >>> core/level_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bit relation is kept across the group.
`timescale 1ns/10ps
module level_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock
	input  wire logic             clk_i,
	// Levels
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				meta_q[g] <= async_i[g];
				sync_o[g] <= meta_q[g];
			end
		end
	endgenerate

endmodule

// >>> core/switch_spi_port.sv
// Serial command port of a dual channel power switch: 16-bit slave, daisy chainable.
// Assumes sclk_i idles low, data sampled on rising and driven on falling edges,
// and that sclk_i is quiet while chip_select_n_i is high.
//
// Notes on behaviour
// R1: Output repeats input sixteen bits later.
// R2: Master keeps select low until word arrives.
// R3: Execute command only on select rising.
// R4: Master toggles watchdog bit every timeout.
// R5: Whole word even parity, checked here.
// R6: Bank bit picks channel register copy.
// R7: Bits 12..10 decode the input register.
// R8: Low ten bits are data or readback select.
// R9: Resets clear registers; parallel bit may survive.
// R10: Per channel registers doubled; global once.
// R11: Readback select returns register next transfer.
// R12: Eight readback codes, bank bit prefixed.
// R13: Output word: echo, fault, address, mode, data.
// R14: Master writes bit 9 zero, calibration pattern.
// R15: Drop wrong length or bad parity words.
// R16: First sixteen output bits: selected register.
// R17: After latch, tristate output, refresh status.
// R18: Master keeps reset pin high during transfers.
`timescale 1ns/10ps
module switch_spi_port (
	// System clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	// Serial link
	input  wire logic                     sclk_i,
	input  wire logic                     chip_select_n_i,
	input  wire logic                     si_i,
	output logic                          so_o,
	output logic                          so_oe_o,
	// Device pins
	input  wire logic                     reset_n_i,
	input  wire logic                     vdd_fail_i,
	// Switch core
	input  wire switch_spi_pkg::live_t    live_i,
	output switch_spi_pkg::config_t       config_o,
	output logic      [1:0]               calibrate_o,
	output logic                          watchdog_toggle_o
);

	// ---------------------------------------------------------------
	// Link domain
	// ---------------------------------------------------------------
	logic [15:0]                          shift_q;
	logic [switch_spi_pkg::CNT_BITS-1:0]  bit_cnt_q;
	logic                                 any_bit_q;
	logic                                 so_neg_q;
	logic                                 so_started_q;
	logic [15:0]                          tx_q;

	// Select high clears the frame marker; sclk is quiet then
	always_ff @(posedge sclk_i or posedge chip_select_n_i) begin
		if (chip_select_n_i) begin
			any_bit_q <= 1'b0;
		end else begin
			any_bit_q <= 1'b1;
		end
	end

	// The count survives select rising, so the word length is still
	// there when the system side judges the frame
	always_ff @(posedge sclk_i) begin
		if (!any_bit_q) begin
			bit_cnt_q <= 4'h1;
		end else begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// The same register carries the outgoing word and the incoming bits,
	// so every input bit leaves sixteen clocks later
	always_ff @(posedge sclk_i) begin
		if (!any_bit_q) begin
			shift_q <= {tx_q[14:0], si_i}; // R16
		end else begin
			shift_q <= {shift_q[14:0], si_i}; // R1
		end
	end

	always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
		if (chip_select_n_i) begin
			so_neg_q     <= 1'b0;
			so_started_q <= 1'b0;
		end else begin
			so_neg_q     <= shift_q[15];
			so_started_q <= 1'b1;
		end
	end

	// Most significant bit is on the pin as soon as select falls
	assign so_o    = so_started_q ? so_neg_q : tx_q[15]; // R16
	assign so_oe_o = ~chip_select_n_i; // R17

	// ---------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------
	logic [3:0] pins_sync;
	logic       cs_n_s;
	logic       reset_n_s;
	logic       vdd_fail_s;
	logic       bits_s;

	level_sync #(
		.WIDTH (4)
	) u_pin_sync (
		.clk_i   (clk_i),
		.async_i ({chip_select_n_i, reset_n_i, vdd_fail_i, any_bit_q}),
		.sync_o  (pins_sync)
	);

	assign cs_n_s     = pins_sync[3];
	assign reset_n_s  = pins_sync[2];
	assign vdd_fail_s = pins_sync[1];
	assign bits_s     = pins_sync[0];

	logic cs_n_prev_q;
	logic frame_end;
	logic pin_reset;
	logic supply_reset;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cs_n_prev_q <= 1'b1;
		end else begin
			cs_n_prev_q <= cs_n_s;
		end
	end

	assign frame_end    = cs_n_s & ~cs_n_prev_q; // R3
	assign pin_reset    = ~reset_n_s; // R18
	assign supply_reset = vdd_fail_s;

	logic bits_seen_q;
	logic supply_prev_q;

	// Remembers that the frame clocked at least one bit; the link marker
	// itself is gone as soon as select rises
	always_ff @(posedge clk_i) begin
		if (srst_i || frame_end) begin
			bits_seen_q <= 1'b0;
		end else if (bits_s && !cs_n_s) begin
			bits_seen_q <= 1'b1; // R15
		end
	end

	// First cycle of a supply failure decides whether the parallel bit stays
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			supply_prev_q <= 1'b0;
		end else begin
			supply_prev_q <= supply_reset;
		end
	end

	// ---------------------------------------------------------------
	// Word acceptance
	// ---------------------------------------------------------------
	// The link registers stand still while select is high, so they are
	// read here only after the synchronised select has risen
	switch_spi_pkg::in_word_t rx_word;
	logic                     length_ok;
	logic                     parity_ok;
	logic                     accept;
	logic                     reject;

	assign rx_word   = switch_spi_pkg::in_word_t'(shift_q);
	assign length_ok = bits_seen_q & (bit_cnt_q == '0); // R15
	assign parity_ok = ~(^shift_q); // R5
	assign accept    = frame_end & length_ok & parity_ok & reset_n_s; // R15
	assign reject    = frame_end & ~(length_ok & parity_ok);

	function automatic logic is_write(input switch_spi_pkg::in_word_t w,
	                                  input logic [2:0] addr);
		is_write = (w.addr == addr); // R7
	endfunction

	// ---------------------------------------------------------------
	// Input registers
	// ---------------------------------------------------------------
	logic [1:0][8:0] duty_q;
	logic [1:0][8:0] chan_conf_q;
	logic [1:0][8:0] overcurrent_q;
	logic [1:0][8:0] retry_q;
	logic [8:0]      global_q;
	logic [3:0]      readback_sel_q;
	logic            clear_all;

	assign clear_all = srst_i | pin_reset | supply_reset; // R9

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bank
			logic hit;
			assign hit = accept & (rx_word.bank == 1'(b)); // R6

			always_ff @(posedge clk_i) begin
				if (clear_all) begin
					duty_q[b] <= switch_spi_pkg::REG_RESET; // R9
				end else if (hit && is_write(rx_word, switch_spi_pkg::IN_DUTY)) begin
					duty_q[b] <= rx_word.data[8:0]; // R8
				end
			end

			always_ff @(posedge clk_i) begin
				if (clear_all) begin
					chan_conf_q[b] <= switch_spi_pkg::REG_RESET;
				end else if (hit && is_write(rx_word, switch_spi_pkg::IN_CHAN_CONF)) begin
					chan_conf_q[b] <= rx_word.data[8:0]; // R10
				end
			end

			always_ff @(posedge clk_i) begin
				if (clear_all) begin
					overcurrent_q[b] <= switch_spi_pkg::REG_RESET;
				end else if (hit && is_write(rx_word, switch_spi_pkg::IN_OVERCURRENT)) begin
					overcurrent_q[b] <= rx_word.data[8:0]; // R10
				end
			end

			// Only the offset bit and the low retry controls are writable
			always_ff @(posedge clk_i) begin
				if (clear_all) begin
					retry_q[b] <= switch_spi_pkg::REG_RESET;
				end else if (hit && is_write(rx_word, switch_spi_pkg::IN_RETRY)) begin
					retry_q[b] <= rx_word.data[8:0] & switch_spi_pkg::RETRY_WR_MASK;
				end
			end

			// One clock pulse per correct calibration command
			always_ff @(posedge clk_i) begin
				if (clear_all) begin
					calibrate_o[b] <= 1'b0;
				end else begin
					calibrate_o[b] <= hit && is_write(rx_word, switch_spi_pkg::IN_CALIBRATE)
					                  && (rx_word.data == switch_spi_pkg::CAL_PATTERN);
				end
			end
		end
	endgenerate

	// Global register exists once; the bank bit is not looked at
	always_ff @(posedge clk_i) begin
		if (srst_i || pin_reset) begin
			global_q <= switch_spi_pkg::REG_RESET; // R9
		end else if (supply_reset) begin
			global_q <= switch_spi_pkg::REG_RESET;
			if (global_q[switch_spi_pkg::GCR_VDDFAIL_POS] || supply_prev_q) begin
				global_q[switch_spi_pkg::GCR_PARALLEL_POS] <=
					global_q[switch_spi_pkg::GCR_PARALLEL_POS]; // R9
			end
		end else if (accept && is_write(rx_word, switch_spi_pkg::IN_GLOBAL)) begin
			global_q <= rx_word.data[8:0]; // R10
		end
	end

	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			readback_sel_q <= switch_spi_pkg::SEL_RESET;
		end else if (accept && is_write(rx_word, switch_spi_pkg::IN_READBACK)) begin
			readback_sel_q <= {rx_word.bank, rx_word.data[2:0]}; // R11
		end
	end

	assign config_o.duty        = duty_q;
	assign config_o.chan_conf   = chan_conf_q;
	assign config_o.overcurrent = overcurrent_q;
	assign config_o.retry       = retry_q;
	assign config_o.global_conf = global_q;

	// ---------------------------------------------------------------
	// Status snapshot, watchdog and parity flags
	// ---------------------------------------------------------------
	logic [8:0] status_q;
	logic       wd_echo_q;
	logic       parity_fault_q;

	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			status_q <= switch_spi_pkg::REG_RESET;
		end else if (accept) begin
			status_q <= live_i.status; // R17
		end
	end

	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			wd_echo_q         <= 1'b0;
			watchdog_toggle_o <= 1'b0;
		end else begin
			watchdog_toggle_o <= accept && (rx_word.wd != wd_echo_q); // R4
			if (accept) begin
				wd_echo_q <= rx_word.wd;
			end
		end
	end

	// A dropped word raises the flag; the next accepted word clears it
	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			parity_fault_q <= 1'b0;
		end else if (reject) begin
			parity_fault_q <= 1'b1; // R15
		end else if (accept) begin
			parity_fault_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Readback word
	// ---------------------------------------------------------------
	logic [8:0]                bank_data;
	logic                      sel_bank;
	switch_spi_pkg::out_word_t tx_word;

	assign sel_bank = readback_sel_q[3];

	always_comb begin
		case (readback_sel_q[2:0]) // R12
			switch_spi_pkg::OUT_STATUS:    bank_data = status_q;
			switch_spi_pkg::OUT_FAULT:     bank_data = live_i.fault[sel_bank];
			switch_spi_pkg::OUT_DUTY:      bank_data = duty_q[sel_bank];
			switch_spi_pkg::OUT_CHAN_CONF: bank_data = chan_conf_q[sel_bank];
			switch_spi_pkg::OUT_OVERCUR:   bank_data = overcurrent_q[sel_bank];
			switch_spi_pkg::OUT_RETRY:     bank_data = {retry_q[sel_bank][8],
			                                            live_i.retry_count[sel_bank],
			                                            retry_q[sel_bank][3:0]};
			switch_spi_pkg::OUT_GLOBAL:    bank_data = global_q;
			switch_spi_pkg::OUT_DIAG:      bank_data = live_i.diag;
			default:                       bank_data = switch_spi_pkg::REG_RESET;
		endcase
	end

	always_comb begin
		tx_word.wd           = wd_echo_q; // R13
		tx_word.parity_fault = parity_fault_q;
		tx_word.sel          = readback_sel_q;
		tx_word.normal_mode  = live_i.normal_mode;
		tx_word.data         = bank_data;
	end

	// Frozen while select is low so the link shifts a stable word
	always_ff @(posedge clk_i) begin
		if (clear_all) begin
			tx_q <= switch_spi_pkg::TX_RESET;
		end else if (cs_n_s && cs_n_prev_q) begin
			tx_q <= tx_word; // R11
		end
	end

endmodule

// >>> tb/switch_spi_port_asserts.sv
// Checker for the switch serial command port, bound onto its ports.
// Assumes config and pulses are registered in the clk_i domain.
`timescale 1ns/10ps
module switch_spi_port_asserts (
	// Clock and reset
	input wire logic                    clk_i,
	input wire logic                    srst_i,
	// Pins
	input wire logic                    chip_select_n_i,
	input wire logic                    so_oe_o,
	input wire logic                    reset_n_i,
	input wire logic                    vdd_fail_i,
	// Core side
	input wire switch_spi_pkg::config_t config_o,
	input wire logic [1:0]              calibrate_o,
	input wire logic                    watchdog_toggle_o
);
	logic       cs_q;
	logic [3:0] quiet_q;

	always_ff @(posedge clk_i) begin
		cs_q <= chip_select_n_i;
	end

	// Cycles since the last select rise or reset, saturating
	always_ff @(posedge clk_i) begin
		if (srst_i || !reset_n_i || vdd_fail_i || (chip_select_n_i && !cs_q)) begin
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hF) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_oe_follows_select: assert property (so_oe_o == !chip_select_n_i)
		else $error("output enable differs from select");
	a_idle_config_steady: assert property (quiet_q >= 4'hA |->
		$stable(config_o) && calibrate_o == 2'h0 && !watchdog_toggle_o)
		else $error("config changed away from a select rise");
	a_cal_after_rise: assert property (calibrate_o != 2'h0 |-> quiet_q inside {[4'h1:4'h9]})
		else $error("calibration pulse not after select rise");
	a_cal_one_cycle: assert property (calibrate_o != 2'h0 |=> calibrate_o == 2'h0)
		else $error("calibration pulse too long");
	a_cal_one_bank: assert property (calibrate_o != 2'h3)
		else $error("calibration pulse on both banks");
	a_wd_one_cycle: assert property (watchdog_toggle_o |=> !watchdog_toggle_o)
		else $error("watchdog pulse too long");
	a_srst_clears: assert property ($fell(srst_i) |-> config_o == '0)
		else $error("config not cleared by reset");
	a_pin_reset_clears: assert property (!reset_n_i [*5] |-> config_o == '0)
		else $error("config not cleared by reset pin");
	a_vdd_clears_regs: assert property (vdd_fail_i [*5] |->
		config_o.duty == '0 && config_o.retry == '0)
		else $error("config not cleared by supply failure");
	a_retry_mask_kept: assert property (
		(config_o.retry[0] & ~switch_spi_pkg::RETRY_WR_MASK) == 9'h000 &&
		(config_o.retry[1] & ~switch_spi_pkg::RETRY_WR_MASK) == 9'h000)
		else $error("retry bit outside writable mask set");

	c_cal_bank1: cover property (calibrate_o[1]);
	c_wd_pulse: cover property (watchdog_toggle_o);
	c_pin_reset: cover property (!reset_n_i [*5]);
endmodule

bind switch_spi_port switch_spi_port_asserts chk (
	.clk_i            (clk_i),
	.srst_i           (srst_i),
	.chip_select_n_i  (chip_select_n_i),
	.so_oe_o          (so_oe_o),
	.reset_n_i        (reset_n_i),
	.vdd_fail_i       (vdd_fail_i),
	.config_o         (config_o),
	.calibrate_o      (calibrate_o),
	.watchdog_toggle_o(watchdog_toggle_o)
);

// >>> tb/spi_master_model.sv
// Serial master driving the command port with 160 ns clock periods.
// Assumes the slave samples on rising and shifts out on falling edges.
`timescale 1ns/10ps
module spi_master_model (
	// Serial link
	output logic      sclk_o,
	output logic      chip_select_n_o,
	output logic      si_o,
	input  wire logic so_i
);
	initial begin
		sclk_o = 1'b0;
		chip_select_n_o = 1'b1;
		si_o = 1'b0;
	end

	// Shifts out the low n bits of tx, MSB first; select held low throughout
	task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = '0;
		#7 chip_select_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si_o = tx[i];
			#80 sclk_o = 1'b1;
			rx = {rx[30:0], so_i};
			#80 sclk_o = 1'b0;
		end
		#80 chip_select_n_o = 1'b1;
		si_o = ~si_o;
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the switch serial command port.
// Assumes the master model's frame task and a fixed live core state.
`timescale 1ns/10ps
module testbench;
	logic                    clk_i = 1'b0;
	logic                    srst_i = 1'b1;
	logic                    reset_n_i = 1'b1;
	logic                    vdd_fail_i = 1'b0;
	logic                    sclk, cs_n, si, so, so_oe, wdt, wd, pw;
	logic [1:0]              cal;
	logic [31:0]             rx;
	logic [8:0]              exp_rb [8];
	switch_spi_pkg::live_t   live;
	switch_spi_pkg::config_t cfg;
	int                      n_errors = 0, comparisons = 0, n_cal = 0, n_wd = 0, k;

	assign live = {9'h0A5, 9'h1C2, 9'h033, 4'h9, 4'h6, 9'h15A, 1'b1};
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (cal[1] === 1'b1) n_cal++;
		if (wdt === 1'b1) n_wd++;
	end

	switch_spi_port dut (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk),
		.chip_select_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
		.reset_n_i(reset_n_i), .vdd_fail_i(vdd_fail_i), .live_i(live),
		.config_o(cfg), .calibrate_o(cal), .watchdog_toggle_o(wdt));
	spi_master_model m (.sclk_o(sclk), .chip_select_n_o(cs_n), .si_o(si), .so_i(so));

	function automatic logic [15:0] mk(input logic b, input logic [2:0] a,
		input logic [9:0] d);
		logic [15:0] w;
		w = {wd, 1'b0, b, a, d};
		w[14] = ^w;
		return w;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic settle();
		repeat (10) @(posedge clk_i);
		#2;
	endtask

	task automatic wr(input logic b, input logic [2:0] a, input logic [9:0] d);
		pw = wd;
		wd = ~wd;
		m.frame({16'h0000, mk(b, a, d)}, 16, rx);
		settle();
	endtask

	task automatic summarize();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#1_000_000;
		n_errors++;
		summarize();
	end

	initial begin
		wd = 1'b0;
		exp_rb = '{9'h0A5, 9'h033, 9'h0AB, 9'h0C3, 9'h111, 9'h060, 9'h048, 9'h15A};
		repeat (12) @(posedge clk_i);
		#2 srst_i = 1'b0;
		settle();
		check({15'h0000, |cfg}, 16'h0000);
		wr(0, switch_spi_pkg::IN_DUTY, 10'h0AB);
		wr(1, switch_spi_pkg::IN_DUTY, 10'h155);
		check(16'(cfg.duty[0]), 16'h00AB);
		check(16'(cfg.duty[1]), 16'h0155);
		check(16'(n_wd), 16'h0002);
		wr(1, switch_spi_pkg::IN_RETRY, 10'h1FF);
		check(16'(cfg.retry[1]), 16'h010F);
		wr(0, switch_spi_pkg::IN_CHAN_CONF, 10'h0C3);
		wr(0, switch_spi_pkg::IN_OVERCURRENT, 10'h111);
		wr(0, switch_spi_pkg::IN_GLOBAL, 10'h048);
		check(16'(cfg.global_conf), 16'h0048);
		$display("test register writes done");
		for (k = 0; k < 9; k++) begin
			wr(0, switch_spi_pkg::IN_READBACK, 10'(k % 8));
			if (k > 0) check(rx[15:0], {pw, 2'b00, 3'(k - 1), 1'b1, exp_rb[k - 1]});
		end
		wr(1, switch_spi_pkg::IN_READBACK, {7'h00, switch_spi_pkg::OUT_DUTY});
		wr(0, switch_spi_pkg::IN_READBACK, 10'h000);
		check(rx[15:0], {pw, 2'b01, switch_spi_pkg::OUT_DUTY, 1'b1, 9'h155});
		$display("test readback done");
		m.frame({16'h0000, mk(0, switch_spi_pkg::IN_DUTY, 10'h001) ^ 16'h4000}, 16, rx);
		settle();
		m.frame({8'hFF, mk(0, switch_spi_pkg::IN_DUTY, 10'h002)}, 24, rx);
		settle();
		check(16'(cfg.duty[0]), 16'h00AB);
		wr(0, switch_spi_pkg::IN_READBACK, 10'h000);
		check({15'h0000, rx[14]}, 16'h0001);
		$display("test refused words done");
		wd = ~wd;
		rx[31:16] = mk(0, switch_spi_pkg::IN_DUTY, 10'h0F0);
		wd = ~wd;
		m.frame({rx[31:16], mk(1, switch_spi_pkg::IN_DUTY, 10'h00F)}, 32, rx);
		settle();
		check(rx[15:0], mk(0, switch_spi_pkg::IN_DUTY, 10'h0F0) ^ 16'hC000);
		check(16'(cfg.duty[0]), 16'h00AB);
		check(16'(cfg.duty[1]), 16'h000F);
		wr(1, switch_spi_pkg::IN_CALIBRATE, switch_spi_pkg::CAL_PATTERN);
		wr(1, switch_spi_pkg::IN_CALIBRATE, 10'h15A);
		check(16'(n_cal), 16'h0001);
		$display("test chain and calibration done");
		@(posedge clk_i);
		#2 vdd_fail_i = 1'b1;
		settle();
		vdd_fail_i = 1'b0;
		settle();
		check(16'(cfg.global_conf), 16'h0040);
		check(16'(cfg.duty[1]), 16'h0000);
		reset_n_i = 1'b0;
		settle();
		reset_n_i = 1'b1;
		settle();
		check(16'(cfg.global_conf), 16'h0000);
		$display("test resets done");
		summarize();
	end
endmodule
